// >>> emx_pkg.sv
// Package of constants and types for the external memory mode and latch strobe block.
`default_nettype none
package emx_pkg;
  // Configuration register layout.
  localparam int unsigned    LPW_LSB      = 0;
  localparam int unsigned    MODE_LSB     = 2;
  localparam int unsigned    MUX_BIT      = 4;
  localparam logic [7:0]     CFG_RESET    = 8'h03;
  localparam logic [7:0]     CFG_WMASK    = 8'h1F;
  localparam logic [7:0]     PAGE_RESET   = 8'h00;
  // Operating modes.
  typedef enum logic [1:0] {
    EMX_MODE_INT   = 2'b00,
    EMX_MODE_SPLIT = 2'b01,
    EMX_MODE_BANK  = 2'b10,
    EMX_MODE_EXT   = 2'b11
  } emx_mode_t;
  // Access sequencer states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    EMX_IDLE  = 2'b00,
    EMX_ALEH  = 2'b01,
    EMX_ALEL  = 2'b11,
    EMX_STRB  = 2'b10
  } emx_state_t;
  // On-chip boundary of the split modes, in address bits.
  localparam int unsigned    ONCHIP_BITS  = 8;
  localparam logic [15:0]    ONCHIP_LIMIT = 16'h0100;
endpackage
`default_nettype wire

// >>> emx_ctrl.sv
// External data move router, address builder and multiplexed latch strobe sequencer.
//
// Function
// - Mode 00 sends every move on-chip, aliased, never starting an off-chip cycle.
// - Modes 01 and 10 send addresses below 256 on-chip, others off-chip.
// - Mode 01 8-bit off-chip moves take high address from port latches.
// - Mode 10 splits as mode 01; 8-bit high byte from page register.
// - Mode 11 sends every move off-chip; on-chip memory is invisible.
// - Latch pulse code 00..11 gives 1..4 cycles high and low.
// - Latch pulse width matters only while multiplex select is 0.
// - Multiplexed versus separate bus chosen solely by multiplex select bit.
// - Multiplexed mode shares data and low address byte on one pin set.
// - Device itself generates the address latch strobe in multiplexed mode.
// - First phase holds strobe high while low address is on shared pins.
// - Falling strobe edge starts the second phase of a multiplexed access.
// - Later second phase carries data under read/write strobe; device drives writes.
// - Multiplex select 0 means multiplexed, 1 means separate address and data.
// - Page register gives high address byte of 8-bit moves for routing; pins carry it only in mode 10.
// - 16-bit off-chip moves drive all sixteen data pointer address bits.
`default_nettype none
module emx_ctrl #(
  parameter int unsigned STROBE_CYCLES = 1
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register port.
  input  wire logic        cfg_we,
  input  wire logic        page_we,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  cfg_rdata,
  output logic      [7:0]  page_rdata,
  // Move request from the core.
  input  wire logic        mv_req,
  input  wire logic        mv_wr,
  input  wire logic        mv_wide,
  input  wire logic [7:0]  mv_lo_addr,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  mv_wdata,
  output logic             mv_busy,
  output logic             mv_done,
  output logic      [7:0]  mv_rdata,
  // On-chip memory side.
  output logic             xram_en,
  output logic             xram_wr,
  output logic      [15:0] xram_addr,
  output logic      [7:0]  xram_wdata,
  input  wire logic [7:0]  xram_rdata,
  // Port latches for the high address pins.
  input  wire logic [7:0]  port_hi_latch,
  // External pins.
  output logic             ale,
  output logic             rd_n,
  output logic             wr_n,
  output logic      [7:0]  addr_hi_o,
  output logic             addr_hi_oe_n,
  output logic      [7:0]  addr_lo_o,
  output logic             addr_lo_oe_n,
  output logic      [7:0]  ad_o,
  output logic             ad_oe_n,
  input  wire logic [7:0]  ad_i
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0]          cfg_r;
  logic [7:0]          page_r;
  logic [7:0]          ad_s1_r;
  logic [7:0]          ad_s2_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r  <= emx_pkg::CFG_RESET;
      page_r <= emx_pkg::PAGE_RESET;
    end else begin
      if (cfg_we) begin
        cfg_r <= reg_wdata & emx_pkg::CFG_WMASK;
      end
      if (page_we) begin
        page_r <= reg_wdata;
      end
    end
  end

  // Read data pins come from off-chip, so they are synchronised first.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ad_s1_r <= 8'h00;
      ad_s2_r <= 8'h00;
    end else begin
      ad_s1_r <= ad_i;
      ad_s2_r <= ad_s1_r;
    end
  end

  assign cfg_rdata  = cfg_r;
  assign page_rdata = page_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Routing and address decode.
  emx_pkg::emx_mode_t  mode;
  logic                mux_sel;
  logic [1:0]          lpw_code;
  logic [15:0]         eff_addr;
  logic                go_off;
  logic                drive_hi;
  logic [2:0]          ale_len;

  function automatic logic below_boundary(input logic [15:0] a);
    below_boundary = (a < emx_pkg::ONCHIP_LIMIT);
  endfunction

  assign mode     = emx_pkg::emx_mode_t'(cfg_r[emx_pkg::MODE_LSB +: 2]);
  assign mux_sel  = cfg_r[emx_pkg::MUX_BIT];
  assign lpw_code = cfg_r[emx_pkg::LPW_LSB +: 2];
  // 8-bit moves take the page register as high byte, 16-bit ones the pointer.
  assign eff_addr = mv_wide ? data_pointer : {page_r, mv_lo_addr};
  assign go_off   = (mode == emx_pkg::EMX_MODE_EXT) ? 1'b1 :
                    (mode == emx_pkg::EMX_MODE_INT) ? 1'b0 :
                    !below_boundary(eff_addr);
  // Only bank-select mode drives the high byte for 8-bit moves.
  assign drive_hi = mv_wide || (mode == emx_pkg::EMX_MODE_BANK);
  assign ale_len  = {1'b0, lpw_code} + 3'd1;

  ////////////////////////////////////////////////////////////////////////////////
  // Access sequencer.
  emx_pkg::emx_state_t state_r;
  emx_pkg::emx_state_t state_nxt;
  logic [2:0]          cnt_r;
  logic                wr_r;
  logic                hi_r;
  logic [15:0]         addr_r;
  logic [7:0]          wdata_r;
  logic                start_off;
  logic                cnt_end;

  assign start_off = mv_req && (state_r == emx_pkg::EMX_IDLE) && go_off;
  assign cnt_end   = (cnt_r == 3'd1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      emx_pkg::EMX_IDLE: begin
        if (start_off) begin
          // Separate bus skips both latch phases entirely.
          state_nxt = mux_sel ? emx_pkg::EMX_STRB : emx_pkg::EMX_ALEH;
        end
      end
      emx_pkg::EMX_ALEH: begin
        if (cnt_end) begin
          state_nxt = emx_pkg::EMX_ALEL;
        end
      end
      emx_pkg::EMX_ALEL: begin
        if (cnt_end) begin
          state_nxt = emx_pkg::EMX_STRB;
        end
      end
      emx_pkg::EMX_STRB: begin
        if (cnt_end) begin
          state_nxt = emx_pkg::EMX_IDLE;
        end
      end
      default: begin
        state_nxt = emx_pkg::EMX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= emx_pkg::EMX_IDLE;
      cnt_r   <= 3'd0;
      wr_r    <= 1'b0;
      hi_r    <= 1'b0;
      addr_r  <= 16'h0000;
      wdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (start_off) begin
        wr_r    <= mv_wr;
        hi_r    <= drive_hi;
        addr_r  <= eff_addr;
        wdata_r <= mv_wdata;
        cnt_r   <= mux_sel ? STROBE_CYCLES[2:0] : ale_len;
      end else if (state_r != state_nxt) begin
        cnt_r <= (state_nxt == emx_pkg::EMX_STRB) ? STROBE_CYCLES[2:0] : ale_len;
      end else if (cnt_r != 3'd0) begin
        cnt_r <= cnt_r - 3'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Completion and read data.
  logic                onchip_go;
  logic                off_last;
  logic                done_r;
  logic [7:0]          rdata_r;

  assign onchip_go = mv_req && (state_r == emx_pkg::EMX_IDLE) && !go_off;
  assign off_last  = (state_r == emx_pkg::EMX_STRB) && cnt_end;
  assign mv_busy   = (state_r != emx_pkg::EMX_IDLE);
  assign mv_done   = done_r;
  assign mv_rdata  = rdata_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_r  <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      done_r <= onchip_go || off_last;
      if (onchip_go && !mv_wr) begin
        rdata_r <= xram_rdata;
      end else if (off_last && !wr_r) begin
        rdata_r <= ad_s2_r;
      end
    end
  end

  // On-chip port; aliasing onto the small space is left to the memory's index width.
  assign xram_en    = onchip_go;
  assign xram_wr    = onchip_go && mv_wr;
  assign xram_addr  = eff_addr;
  assign xram_wdata = mv_wdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive.
  logic                in_mux;
  logic                ph_addr;
  logic                ph_strb;

  assign in_mux  = !mux_sel && mv_busy;
  assign ph_addr = (state_r == emx_pkg::EMX_ALEH) || (state_r == emx_pkg::EMX_ALEL);
  assign ph_strb = (state_r == emx_pkg::EMX_STRB);

  // The latch is transparent while high, so the address stays on the pins for the
  // whole low phase too; that covers the latch hold time.
  assign ale          = in_mux && (state_r == emx_pkg::EMX_ALEH);
  assign rd_n         = !(ph_strb && !wr_r);
  assign wr_n         = !(ph_strb && wr_r);
  // High byte pins are released in modes 01 and 11 for 8-bit moves.
  assign addr_hi_o    = hi_r ? addr_r[15:8] : port_hi_latch;
  assign addr_hi_oe_n = !(mv_busy && hi_r);
  assign addr_lo_o    = addr_r[7:0];
  assign addr_lo_oe_n = !(mv_busy && mux_sel);
  assign ad_o         = (in_mux && ph_addr) ? addr_r[7:0] : wdata_r;
  assign ad_oe_n      = !((in_mux && ph_addr) || (ph_strb && wr_r));

endmodule
`default_nettype wire

// >>> emx_ctrl_chk.sv
// Checker of move routing and latch strobe timing.
`default_nettype none
module emx_ctrl_chk (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Watched ports.
  input wire logic [7:0]  cfg_rdata,
  input wire logic        mv_req,
  input wire logic        mv_wr,
  input wire logic        mv_wide,
  input wire logic [15:0] data_pointer,
  input wire logic        mv_busy,
  input wire logic        mv_done,
  input wire logic        xram_en,
  input wire logic        xram_wr,
  input wire logic        ale,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        ad_oe_n,
  input wire logic        addr_lo_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hi_r;
  logic [2:0] hi_nxt;
  logic       take;
  assign take = mv_req && !mv_busy;
  assign hi_nxt = ale ? hi_r + 3'h1 : 3'h0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hi_r <= 3'h0;
    else hi_r <= hi_nxt;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_idle; !mv_busy |-> !ale; endproperty
  a_idle: assert property (p_idle) else $error("ale idle");
  property p_sep; cfg_rdata[4] |-> !ale; endproperty
  a_sep: assert property (p_sep) else $error("ale sep");
  property p_high; $fell(ale) |-> hi_r == {1'b0, cfg_rdata[1:0]} + 3'h1; endproperty
  a_high: assert property (p_high) else $error("ale high width");
  property p_low;
    $fell(ale) && cfg_rdata[1:0] == 2'b11 |-> (rd_n && wr_n)[*4] ##1 !(rd_n && wr_n);
  endproperty
  a_low: assert property (p_low) else $error("ale low width");
  property p_int; take && cfg_rdata[3:2] == 2'b00 |=> mv_done && !mv_busy; endproperty
  a_int: assert property (p_int) else $error("mode 00");
  property p_ext; take && cfg_rdata[3:2] == 2'b11 |=> mv_busy; endproperty
  a_ext: assert property (p_ext) else $error("mode 11");
  property p_split;
    take && (cfg_rdata[3] ^ cfg_rdata[2]) && mv_wide && data_pointer < 16'h0100 |=> mv_done;
  endproperty
  a_split: assert property (p_split) else $error("split");
  property p_wr; !wr_n |-> !ad_oe_n && rd_n; endproperty
  a_wr: assert property (p_wr) else $error("write drive");
  property p_rd; !rd_n |-> ad_oe_n && wr_n; endproperty
  a_rd: assert property (p_rd) else $error("read release");
  // Mode 00 moves must reach the on-chip port in the very cycle they are taken.
  property p_onw; take && cfg_rdata[3:2] == 2'b00 |-> xram_en && xram_wr == mv_wr; endproperty
  a_onw: assert property (p_onw) else $error("on-chip port");
  property p_exx; cfg_rdata[3:2] == 2'b11 |-> !xram_en; endproperty
  a_exx: assert property (p_exx) else $error("on-chip visible");
  property p_aled; ale |-> !ad_oe_n; endproperty
  a_aled: assert property (p_aled) else $error("address not driven");
  property p_lo; !addr_lo_oe_n |-> cfg_rdata[4] && mv_busy; endproperty
  a_lo: assert property (p_lo) else $error("low address pins");
endmodule
bind emx_ctrl emx_ctrl_chk u_chk (.clk_sys, .rst_n, .cfg_rdata, .mv_req, .mv_wr, .mv_wide,
  .data_pointer, .mv_busy, .mv_done, .xram_en, .xram_wr, .ale, .rd_n, .wr_n, .ad_oe_n,
  .addr_lo_oe_n);
`default_nettype wire

// >>> emx_xmem.sv
// Behavioural external memory with a low address latch.
`default_nettype none
module emx_xmem (
  // Clock and pins.
  input wire logic        clk_sys,
  input wire logic        ale,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        sep,
  input wire logic [7:0]  addr_hi_o,
  input wire logic        addr_hi_oe_n,
  input wire logic [7:0]  port_hi_latch,
  input wire logic [7:0]  addr_lo_o,
  input wire logic [7:0]  ad_o,
  output logic     [7:0]  ad_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat;
  logic [7:0]  last;
  logic [15:0] a;
  always_latch if (ale) lat <= ad_o;
  assign a = {addr_hi_oe_n ? port_hi_latch : addr_hi_o, sep ? addr_lo_o : lat};
  // Released pins show the inverse of the last value, so a stale read cannot pass.
  assign ad_i = !rd_n ? mem[a] : ~last;
  always @(posedge clk_sys) begin
    if (!rd_n) last <= mem[a];
    if (!wr_n) mem[a] <= ad_o;
  end
endmodule
`default_nettype wire

// >>> tb_external_memory_if_modes.sv
// Self-checking bench of the move controller.
`default_nettype none
module tb_external_memory_if_modes;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_n, cfg_we, page_we, mv_req, mv_wr, mv_wide;
  logic [7:0]  reg_wdata, mv_lo_addr, mv_wdata, port_hi_latch, rd;
  logic [15:0] data_pointer, xram_addr;
  logic        mv_busy, mv_done, xram_en, xram_wr, ale, rd_n, wr_n;
  logic        addr_hi_oe_n, addr_lo_oe_n, ad_oe_n;
  logic [7:0]  cfg_rdata, page_rdata, mv_rdata, xram_wdata, xram_rdata;
  logic [7:0]  addr_hi_o, addr_lo_o, ad_o, ad_i;
  int          fails, total_checks, c;
  always #2 clk_sys = ~clk_sys;
  // On-chip memory stand-in answers with the inverted low address.
  assign xram_rdata = ~xram_addr[7:0];
  emx_ctrl #(.STROBE_CYCLES(3)) DUT (.clk_sys, .rst_n, .cfg_we, .page_we, .reg_wdata,
    .cfg_rdata, .page_rdata, .mv_req, .mv_wr, .mv_wide, .mv_lo_addr, .data_pointer,
    .mv_wdata, .mv_busy, .mv_done, .mv_rdata, .xram_en, .xram_wr, .xram_addr, .xram_wdata,
    .xram_rdata, .port_hi_latch, .ale, .rd_n, .wr_n, .addr_hi_o, .addr_hi_oe_n, .addr_lo_o,
    .addr_lo_oe_n, .ad_o, .ad_oe_n, .ad_i);
  emx_xmem u_mem (.clk_sys, .ale, .rd_n, .wr_n, .sep(cfg_rdata[4]), .addr_hi_o,
    .addr_hi_oe_n, .port_hi_latch, .addr_lo_o, .ad_o, .ad_i);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic pg, input logic [7:0] v);
    @(negedge clk_sys);
    {page_we, cfg_we, reg_wdata} = {pg, !pg, v};
    @(negedge clk_sys);
    {page_we, cfg_we} = 2'b00;
  endtask
  task automatic mv(input logic w, input logic wd, input logic [15:0] ad, input logic [7:0] d);
    int n;
    @(negedge clk_sys);
    {mv_req, mv_wr, mv_wide, data_pointer, mv_lo_addr, mv_wdata} = {1'b1, w, wd, ad, ad[7:0], d};
    @(negedge clk_sys);
    mv_req = 1'b0;
    n = 0;
    while (mv_done !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 60) fails++;
    rd = mv_rdata;
  endtask
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    fails++;
    wrap_up;
  end
  initial begin
    clk_sys = 1'b0;
    {rst_n, cfg_we, page_we, mv_req, mv_wr, mv_wide} = 6'h00;
    {reg_wdata, mv_lo_addr, mv_wdata, port_hi_latch, data_pointer} = 48'h0;
    fails = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    chk(cfg_rdata, 8'h03);
    chk(page_rdata, 8'h00);
    wreg(1'b0, 8'hFF);
    chk(cfg_rdata, 8'h1F);
    // Every latch code in both bus styles, external only, full pointer address.
    for (c = 0; c < 8; c++) begin
      wreg(1'b0, {3'h0, c[2], 2'b11, c[1:0]});
      mv(1'b1, 1'b1, 16'h1230 + 16'(c), 8'hA0 + 8'(c));
      mv(1'b0, 1'b1, 16'h1230 + 16'(c), 8'h00);
      chk(rd, 8'hA0 + 8'(c));
    end
    wreg(1'b0, 8'h03);
    mv(1'b0, 1'b1, 16'h1234, 8'h00);
    chk(rd, 8'hCB);
    // An aliased on-chip write must leave the off-chip copy at 0x1231 untouched.
    mv(1'b1, 1'b1, 16'h1231, 8'h5A);
    wreg(1'b0, 8'h08);
    wreg(1'b1, 8'h12);
    mv(1'b0, 1'b0, 16'h0031, 8'h00);
    chk(rd, 8'hA1);
    wreg(1'b1, 8'h00);
    mv(1'b0, 1'b0, 16'h0031, 8'h00);
    chk(rd, 8'hCE);
    wreg(1'b0, 8'h04);
    wreg(1'b1, 8'h05);
    port_hi_latch = 8'h12;
    mv(1'b0, 1'b0, 16'h0032, 8'h00);
    chk(rd, 8'hA2);
    mv(1'b0, 1'b1, 16'h0050, 8'h00);
    chk(rd, 8'hAF);
    wrap_up;
  end
endmodule
`default_nettype wire
